/* hw/ivm_vector_mapper.sv */
// interrupt vector mapper: arbitration by trap, then priority level, natural order on ties, vector address dispatch
`timescale 1ns/1ps
module ivm_vector_mapper import ivm_pkg::*; #(
  parameter int NUM_IRQ = IVM_NUM_IRQ
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic alt_table_select,
  input wire logic [7:0] trap_event,
  input wire logic [NUM_IRQ-1:0] irq_event,
  input wire logic [NUM_IRQ-1:0] flag_clear,
  input wire logic [NUM_IRQ-1:0] irq_enable,
  input wire logic [NUM_IRQ*3-1:0] irq_priority,
  input wire logic [2:0] cpu_priority,
  input wire logic vec_ack,
  output logic vec_req,
  output logic [23:0] vec_addr,
  output logic [6:0] vec_num,
  output logic vec_is_trap,
  output logic [2:0] vec_level,
  output logic [NUM_IRQ-1:0] request_flag_regs,
  output logic [23:0] reset_pc,
  output logic [4:0] flag_reg_idx,
  output logic [3:0] flag_bit_idx,
  output logic [4:0] prio_reg_idx,
  output logic [3:0] prio_bit_lsb
);
  if (NUM_IRQ != IVM_NUM_IRQ) begin : g_chk
    $error("ivm_vector_mapper: NUM_IRQ must match the table size");
  end

  typedef struct packed {
    ivm_state_t st;
    logic [NUM_IRQ-1:0] flags;
    logic [7:0] traps;
    logic req;
    logic is_trap;
    logic [6:0] num;
    logic [2:0] level;
    logic [23:0] addr;
  } ivm_regs_t;

  ivm_regs_t r_r;
  ivm_regs_t r_nxt;
  ivm_map_if map_bus();

  ivm_addr_calc u_calc (
    .m(map_bus.calc)
  );

  logic [NUM_IRQ-1:0] pend;
  logic win_valid;
  logic win_trap;
  logic [6:0] win_num;
  logic [2:0] win_lvl;
  logic [2:0] p;

  // pending sources: flag and enable, implemented only
  assign pend = r_r.flags & irq_enable & IVM_IMPL_MASK;

  // arbitration: traps first, then highest level; scan downward so lower number wins ties
  always_comb begin
    win_valid = 1'b0;
    win_trap = 1'b0;
    win_num = 7'h00;
    win_lvl = 3'h0;
    p = 3'h0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      p = irq_priority[i*3 +: 3];
      if (pend[i] && p > cpu_priority && (!win_valid || p >= win_lvl)) begin
        win_valid = 1'b1;
        win_num = 7'(i);
        win_lvl = p;
      end
    end
    for (int t = IVM_NUM_TRAPS - 1; t >= 0; t--) begin
      if (r_r.traps[t]) begin
        win_valid = 1'b1;
        win_trap = 1'b1;
        win_num = 7'(t);
        win_lvl = 3'h7;
      end
    end
  end

  // calculator sees the registered winner while busy, else the live one
  assign map_bus.is_trap = (r_r.st == IVM_IDLE) ? win_trap : r_r.is_trap;
  assign map_bus.num = (r_r.st == IVM_IDLE) ? win_num : r_r.num;
  assign map_bus.alt_sel = alt_table_select;

  // next state: sticky flags, set beats clear; one vector in flight at a time
  always_comb begin
    r_nxt = r_r;
    // unimplemented numbers never latch a flag, so their positions read zero
    r_nxt.flags = ((r_r.flags & ~flag_clear) | irq_event) & IVM_IMPL_MASK;
    r_nxt.traps = r_r.traps | trap_event;
    case (r_r.st)
      IVM_IDLE: begin
        if (win_valid) begin
          r_nxt.st = IVM_ISSUE;
          r_nxt.req = 1'b1;
          r_nxt.is_trap = win_trap;
          r_nxt.num = win_num;
          r_nxt.level = win_lvl;
          r_nxt.addr = map_bus.vec_addr;
        end
      end
      IVM_ISSUE: begin
        if (vec_ack) begin
          r_nxt.st = IVM_WAIT;
          r_nxt.req = 1'b0;
          // trap status drops once the cpu takes its vector; event in same cycle keeps it
          if (r_r.is_trap) begin
            r_nxt.traps[r_r.num[2:0]] = trap_event[r_r.num[2:0]];
          end
        end
      end
      IVM_WAIT: begin
        // one idle cycle so a cleared flag is seen before re-arbitration
        r_nxt.st = IVM_IDLE;
      end
      default: begin
        r_nxt.st = IVM_IDLE;
        r_nxt.req = 1'b0;
      end
    endcase
  end

  // reset takes no vector path: everything clears, no request raised
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign vec_req = r_r.req;
  assign vec_addr = r_r.addr;
  assign vec_num = r_r.num;
  assign vec_is_trap = r_r.is_trap;
  assign vec_level = r_r.level;
  assign request_flag_regs = r_r.flags;
  assign reset_pc = IVM_RESET_ADDR;
  assign flag_reg_idx = map_bus.flag_reg;
  assign flag_bit_idx = map_bus.flag_bit;
  assign prio_reg_idx = map_bus.prio_reg;
  assign prio_bit_lsb = map_bus.prio_lsb;
endmodule

/* shared/ivm_pkg.sv */
// package for the interrupt vector mapper: table layout, source list, field positions
package ivm_pkg;
  localparam int IVM_ADDR_W = 24;
  localparam int IVM_NUM_W = 7;
  localparam int IVM_NUM_TRAPS = 8;
  localparam int IVM_NUM_IRQ = 118;
  localparam int IVM_NUM_VEC = 126;
  localparam logic [23:0] IVM_RESET_ADDR = 24'h00_0000;
  localparam logic [23:0] IVM_TRAP_BASE = 24'h00_0004;
  localparam logic [23:0] IVM_IRQ_BASE = 24'h00_0014;
  localparam logic [23:0] IVM_ALT_OFFSET = 24'h00_0100;
  localparam int IVM_VEC_STRIDE_SH = 1;
  localparam int IVM_FLAG_REG_SH = 4;
  localparam logic [6:0] IVM_FLAG_BIT_MASK = 7'h0f;
  localparam int IVM_PRIO_REG_SH = 2;
  localparam logic [6:0] IVM_PRIO_SLOT_MASK = 7'h03;
  localparam int IVM_PRIO_SLOT_SH = 2;
  localparam int IVM_PRIO_W = 3;
  // trap source numbers
  localparam logic [2:0] IVM_TRAP_OSC_FAIL = 3'h1;
  localparam logic [2:0] IVM_TRAP_ADDR_ERR = 3'h2;
  localparam logic [2:0] IVM_TRAP_STACK_ERR = 3'h3;
  localparam logic [2:0] IVM_TRAP_MATH_ERR = 3'h4;
  // implemented interrupt vectors, one bit per vector number
  localparam logic [117:0] IVM_IMPL_MASK =
    (118'h1 << 0) | (118'h1 << 1) | (118'h1 << 2) | (118'h1 << 3) | (118'h1 << 5) |
    (118'h1 << 6) | (118'h1 << 7) | (118'h1 << 8) | (118'h1 << 9) | (118'h1 << 10) |
    (118'h1 << 11) | (118'h1 << 12) | (118'h1 << 13) | (118'h1 << 16) | (118'h1 << 17) |
    (118'h1 << 18) | (118'h1 << 19) | (118'h1 << 20) | (118'h1 << 22) | (118'h1 << 23) |
    (118'h1 << 25) | (118'h1 << 26) | (118'h1 << 27) | (118'h1 << 28) | (118'h1 << 29) |
    (118'h1 << 30) | (118'h1 << 31) | (118'h1 << 32) | (118'h1 << 33) | (118'h1 << 37) |
    (118'h1 << 38) | (118'h1 << 39) | (118'h1 << 40) | (118'h1 << 41) | (118'h1 << 42) |
    (118'h1 << 43) | (118'h1 << 44) | (118'h1 << 45) | (118'h1 << 49) | (118'h1 << 50) |
    (118'h1 << 53) | (118'h1 << 54) | (118'h1 << 62) | (118'h1 << 65) | (118'h1 << 66) |
    (118'h1 << 67) | (118'h1 << 72) | (118'h1 << 77) | (118'h1 << 81) | (118'h1 << 82) |
    (118'h1 << 83) | (118'h1 << 84) | (118'h1 << 85) | (118'h1 << 86) | (118'h1 << 87) |
    (118'h1 << 88) | (118'h1 << 89) | (118'h1 << 90) | (118'h1 << 91) | (118'h1 << 92) |
    (118'h1 << 93);
  // dispatch sequencer states
  typedef enum logic [1:0] {
    IVM_IDLE = 2'b00,
    IVM_ISSUE = 2'b01,
    IVM_WAIT = 2'b10
  } ivm_state_t;
endpackage

/* shared/ivm_map_if.sv */
// interface between the mapper top and its address calculator
`timescale 1ns/1ps
interface ivm_map_if;
  logic is_trap;
  logic [6:0] num;
  logic alt_sel;
  logic [23:0] vec_addr;
  logic [4:0] flag_reg;
  logic [3:0] flag_bit;
  logic [4:0] prio_reg;
  logic [3:0] prio_lsb;
  logic impl;
  modport client (output is_trap, output num, output alt_sel,
    input vec_addr, input flag_reg, input flag_bit, input prio_reg, input prio_lsb, input impl);
  modport calc (input is_trap, input num, input alt_sel,
    output vec_addr, output flag_reg, output flag_bit, output prio_reg, output prio_lsb, output impl);
endinterface

/* hw/ivm_addr_calc.sv */
// vector number to table address and bit position calculator
`timescale 1ns/1ps
module ivm_addr_calc import ivm_pkg::*; (
  ivm_map_if.calc m
);
  logic [23:0] base;
  logic [23:0] prim;
  logic in_range;
  // trap and interrupt slots are two address units apart
  always_comb begin
    base = m.is_trap ? IVM_TRAP_BASE : IVM_IRQ_BASE;
    prim = base + (24'(m.num) << IVM_VEC_STRIDE_SH);
    m.vec_addr = m.alt_sel ? prim + IVM_ALT_OFFSET : prim;
  end
  // unimplemented numbers map to zero positions
  always_comb begin
    in_range = m.is_trap ? (m.num < 7'(IVM_NUM_TRAPS)) : (m.num < 7'(IVM_NUM_IRQ));
    m.impl = in_range && (m.is_trap || IVM_IMPL_MASK[m.num]);
    m.flag_reg = m.impl ? 5'(m.num >> IVM_FLAG_REG_SH) : 5'h0;
    m.flag_bit = m.impl ? 4'(m.num & IVM_FLAG_BIT_MASK) : 4'h0;
    m.prio_reg = m.impl ? 5'(m.num >> IVM_PRIO_REG_SH) : 5'h0;
    m.prio_lsb = m.impl ? 4'((m.num & IVM_PRIO_SLOT_MASK) << IVM_PRIO_SLOT_SH) : 4'h0;
  end
endmodule

/* tb/ivm_asserts.sv */
// port checker for the interrupt vector mapper
`timescale 1ns/1ps
module ivm_asserts import ivm_pkg::*; #(
  parameter int NUM_IRQ = IVM_NUM_IRQ
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic alt_table_select,
  input wire logic [NUM_IRQ-1:0] irq_event,
  input wire logic [NUM_IRQ-1:0] flag_clear,
  input wire logic vec_ack,
  input wire logic vec_req,
  input wire logic [23:0] vec_addr,
  input wire logic [6:0] vec_num,
  input wire logic vec_is_trap,
  input wire logic [NUM_IRQ-1:0] request_flag_regs,
  input wire logic [23:0] reset_pc,
  input wire logic [4:0] flag_reg_idx,
  input wire logic [3:0] flag_bit_idx,
  input wire logic [4:0] prio_reg_idx,
  input wire logic [3:0] prio_bit_lsb
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // helpers; alt is read live, so the bench holds it across a dispatch
  wire logic [NUM_IRQ-1:0] impl = NUM_IRQ'(IVM_IMPL_MASK);
  wire logic [NUM_IRQ-1:0] ev = irq_event & impl;
  wire logic [23:0] base = vec_is_trap ? 24'h00_0004 : 24'h00_0014;
  wire logic [23:0] alt = alt_table_select ? 24'h00_0100 : 24'h00_0000;
  sequence s_hold; vec_req && !vec_ack; endsequence
  sequence s_ack; vec_req && vec_ack; endsequence
  property p_pc; reset_pc == 24'h00_0000; endproperty
  a_pc: assert property (p_pc) else $error("reset pc not zero");
  property p_addr; $rose(vec_req) |-> vec_addr == base + {vec_num, 1'b0} + alt; endproperty
  a_addr: assert property (p_addr) else $error("vector address wrong");
  property p_stand; s_hold |=> vec_req && $stable(vec_addr) && $stable(vec_num); endproperty
  a_stand: assert property (p_stand) else $error("vector dropped early");
  property p_drop; s_ack |=> !vec_req; endproperty
  a_drop: assert property (p_drop) else $error("request kept after ack");
  property p_fset; 1'b1 |=> (request_flag_regs & $past(ev)) == $past(ev); endproperty
  a_fset: assert property (p_fset) else $error("flag not set");
  property p_fclr; 1'b1 |=> ($past(request_flag_regs) & ~request_flag_regs & ~$past(flag_clear)) == '0; endproperty
  a_fclr: assert property (p_fclr) else $error("flag lost");
  property p_unimpl; (request_flag_regs & ~impl) == '0; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused flag set");
  property p_pos; vec_req && !vec_is_trap |-> flag_reg_idx == 5'(vec_num >> 4) && flag_bit_idx == vec_num[3:0]
    && prio_reg_idx == 5'(vec_num >> 2) && prio_bit_lsb == {vec_num[1:0], 2'b00}; endproperty
  a_pos: assert property (p_pos) else $error("bit position wrong");
endmodule

/* tb/ivm_cpu_model.sv */
// cpu side model: takes each vector after a programmable stall
`timescale 1ns/1ps
module ivm_cpu_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic vec_req,
  input wire logic [23:0] vec_addr,
  input wire logic [3:0] stall,
  output logic vec_ack,
  output logic [23:0] handler
);
  logic [3:0] cnt_r;
  // one ack pulse per vector; the stall exercises a slow fetch
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vec_ack <= 1'b0;
      cnt_r <= 4'h0;
      handler <= 24'h00_0000;
    end else if (vec_ack) begin
      vec_ack <= 1'b0;
      cnt_r <= 4'h0;
      // unused slots would hold the resetting default handler
      handler <= {16'h0001, vec_addr[7:0]}; // same entry in either table
    end else if (vec_req) begin
      vec_ack <= (cnt_r >= stall);
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

/* tb/ivm_vector_mapper_tb_top.sv */
// testbench for the interrupt vector mapper
`timescale 1ns/1ps
module ivm_vector_mapper_tb_top import ivm_pkg::*;;
  logic clk_sys = 0, resetn = 0, alt_table_select = 0, vec_ack, vec_req, vec_is_trap;
  logic [7:0] trap_event = '0;
  logic [117:0] irq_event = '0, flag_clear = '0, irq_enable = '1, request_flag_regs;
  logic [353:0] irq_priority = {118{3'b001}};
  logic [2:0] cpu_priority = '0, vec_level;
  logic [23:0] vec_addr, reset_pc;
  logic [6:0] vec_num;
  logic [4:0] flag_reg_idx, prio_reg_idx;
  logic [3:0] flag_bit_idx, prio_bit_lsb, stall = '0;
  int error_cnt = 0, check_count = 0, cyc = 0;
  ivm_vector_mapper #(.NUM_IRQ(118)) i_ivm_vector_mapper (.*);
  ivm_cpu_model i_ivm_cpu_model (.*, .handler());
  initial forever #2 clk_sys = ~clk_sys;
  // hang guard, far above the 150 or so cycles the tests need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] a, input logic [23:0] e);
    check_count++;
    if (a !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic fire(input logic [117:0] im, input logic [7:0] tm);
    irq_event <= im;
    trap_event <= tm;
    @(posedge clk_sys);
    irq_event <= '0;
    trap_event <= '0;
  endtask
  // wait for the ack edge, judge the address, clear the flag before it re-fires
  task automatic take(input int n, input bit tr);
    logic [23:0] e;
    e = (tr ? 24'h00_0004 : 24'h00_0014) + 24'(2 * n) + (alt_table_select ? 24'h00_0100 : 24'h00_0000);
    for (int k = 0; k < 30 && !(vec_req === 1'b1 && vec_ack === 1'b1); k++) @(posedge clk_sys);
    chk(vec_ack === 1'b1 ? vec_addr : 24'hff_ffff, e);
    chk({17'h0, vec_num}, 24'(n));
    chk({21'h0, vec_level}, tr ? 24'h00_0007 : 24'(irq_priority[n*3 +: 3]));
    if (!tr) begin
      chk({23'h0, request_flag_regs[n]}, 24'h1);
      flag_clear[n] <= 1'b1;
    end
    @(posedge clk_sys);
    flag_clear <= '0;
  endtask
  task automatic t_vectors;
    int v[3] = '{0, 13, 93};
    for (int a = 0; a < 2; a++) begin
      alt_table_select <= a[0];
      stall <= 4'(3 * a);
      for (int t = 1; t < 5; t++) begin
        fire('0, 8'(1 << t));
        take(t, 1);
      end
      foreach (v[i]) begin
        fire(118'h1 << v[i], '0);
        take(v[i], 0);
      end
    end
  endtask
  task automatic t_order;
    fire((118'h1 << 18) | (118'h1 << 13), '0);
    take(13, 0);
    take(18, 0);
    irq_priority[56:54] <= 3'h5;
    fire((118'h1 << 18) | (118'h1 << 13), '0);
    take(18, 0);
    take(13, 0);
  endtask
  task automatic t_mask;
    irq_enable[13] <= 1'b0;
    fire(118'h1 << 13, '0);
    repeat (8) @(posedge clk_sys);
    chk({23'h0, vec_req}, 24'h0);
    irq_enable[13] <= 1'b1;
    take(13, 0);
    fire(118'h1 << 14, '0);
    repeat (8) @(posedge clk_sys);
    chk({vec_req, request_flag_regs[14]}, 24'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    chk(reset_pc, 24'h00_0000);
    chk({23'h0, vec_req}, 24'h0);
    $display("reset test done");
    t_vectors();
    $display("vector test done");
    t_order();
    $display("order test done");
    t_mask();
    $display("mask test done");
    give_verdict();
  end
endmodule
bind ivm_vector_mapper ivm_asserts #(.NUM_IRQ(NUM_IRQ)) i_ivm_asserts (.*);
